// file: core/msm_regs.svh
// Purpose: offsets, field positions and reset values of the mailbox port
// Assumes: apb byte addresses, one register per aligned 32-bit word
// Notes: definitions only
`ifndef MSM_REGS_SVH
`define MSM_REGS_SVH

`define MSM_AW 12
`define MSM_STATUS_OFF 12'h000
`define MSM_IN_BASE 12'h010
`define MSM_OUT_BASE 12'h020
`define MSM_IRQ_STS_OFF 12'h030
`define MSM_IRQ_MASK_OFF 12'h034

`define MSM_SEL_STATUS 2'h3
`define MSM_SEL_ZERO 2'h0

`define MSM_ST_IN_LSB 0
`define MSM_ST_IN_PEND 3
`define MSM_ST_OUT_LSB 4
`define MSM_ST_ATTN 7

`define MSM_EV_IN0_WR 0
`define MSM_EV_OUT0_RD 1
`define MSM_EV_W 2

`define MSM_RST_BYTE 8'h00
`define MSM_RST_FLAGS 3'h0
`define MSM_RST_EV 2'h0
`define MSM_RST_WORD 32'h0000_0000

`endif

// file: core/msm_pkg.sv
// Purpose: types shared by the mailbox port
// Assumes: nothing beyond the register header
// Notes: pins travel as one packed struct after synchronising
package msm_pkg;

  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] addr;
    logic [7:0] data;
  } msm_pins_t;

  typedef enum logic [1:0] {
    MSM_IDLE,
    MSM_WRITE,
    MSM_READ
  } msm_phase_t;

endpackage : msm_pkg

// file: core/msm_port.sv
// Purpose: parallel mailbox port between an outside master and the local cpu
// Assumes: master strobes are slow against pclk; each strobe low >= 3 cycles
// Notes: local cpu reaches the mailbox over apb; pins pass two flops first
`timescale 1ns/1ps
`default_nettype none
`include "msm_regs.svh"

//Contract
// - three byte registers each direction, six total
// - one status register readable by both sides
// - master writes inbound, local cpu reads them
// - local cpu writes outbound, master reads them
// - local write to outbound zero asserts attention
// - master write inbound zero raises enabled interrupt
// - only register zero writes alert other side
// - any store sets that register full flag
// - read by opposite side clears full flag
// - status shows pending requests from both sides
// - senders load one, two, then zero last
module msm_port
  import msm_pkg::*;
#(
  parameter int NREG = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`MSM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic port_select_n,
  input wire logic port_read_strobe_n,
  input wire logic port_write_strobe_n,
  input wire logic reg_select_bit0,
  input wire logic reg_select_bit1,
  input wire logic [7:0] port_data_in,
  output logic [7:0] port_data_out,
  output logic port_data_oe_n,
  output logic master_attention_out_n
);

  // one-hot select of a register inside a three-word bank
  function automatic logic [NREG-1:0] bank_hit(
    input logic [`MSM_AW-1:0] a,
    input logic [`MSM_AW-1:0] base
  );
    logic [NREG-1:0] h;
    h = '0;
    for (int i = 0; i < NREG; i++) begin
      if (a == base + `MSM_AW'(4 * i)) begin
        h[i] = 1'b1;
      end
    end
    return h;
  endfunction

  // status byte seen identically by both sides
  function automatic logic [7:0] status_byte(
    input logic [NREG-1:0] inf,
    input logic [NREG-1:0] outf,
    input logic in_pend,
    input logic attn
  );
    logic [7:0] s;
    s = '0;
    s[`MSM_ST_IN_LSB +: NREG] = inf;
    s[`MSM_ST_IN_PEND] = in_pend;
    s[`MSM_ST_OUT_LSB +: NREG] = outf;
    s[`MSM_ST_ATTN] = attn;
    return s;
  endfunction

  msm_pins_t pin_raw;
  msm_pins_t pin_meta_r;
  msm_pins_t pin_r;
  msm_phase_t phase_r;
  logic [1:0] acc_sel_r;
  logic [7:0] acc_data_r;
  logic [7:0] in_reg_r [NREG];
  logic [7:0] out_reg_r [NREG];
  logic [NREG-1:0] in_full_r;
  logic [NREG-1:0] out_full_r;
  logic attn_r;
  logic [`MSM_EV_W-1:0] ev_r;
  logic [`MSM_EV_W-1:0] mask_r;
  logic [31:0] prdata_r;
  logic [7:0] port_data_r;

  logic m_strobe_wr;
  logic m_strobe_rd;
  logic m_wr_done;
  logic m_rd_done;
  logic apb_setup;
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic [NREG-1:0] hit_in;
  logic [NREG-1:0] hit_out;
  logic hit_status;
  logic hit_ists;
  logic hit_mask;
  logic mapped;
  logic [7:0] status_now;

  assign pin_raw = '{
    sel_n: port_select_n,
    rd_n: port_read_strobe_n,
    wr_n: port_write_strobe_n,
    addr: {reg_select_bit1, reg_select_bit0},
    data: port_data_in
  };

  // two flops before any logic looks at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= '1;
      pin_r <= '1;
    end else if (ce) begin
      pin_meta_r <= pin_raw;
      pin_r <= pin_meta_r;
    end
  end

  assign m_strobe_wr = !pin_r.sel_n && !pin_r.wr_n;
  assign m_strobe_rd = !pin_r.sel_n && !pin_r.rd_n;
  assign m_wr_done = (phase_r == MSM_WRITE) && !m_strobe_wr;
  assign m_rd_done = (phase_r == MSM_READ) && !m_strobe_rd;

  // master access tracking; a write commits at the strobe's end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= MSM_IDLE;
      acc_sel_r <= `MSM_SEL_ZERO;
      acc_data_r <= `MSM_RST_BYTE;
    end else if (ce) begin
      case (phase_r)
        MSM_IDLE: begin
          acc_sel_r <= pin_r.addr;
          if (m_strobe_wr) begin
            phase_r <= MSM_WRITE;
          end else if (m_strobe_rd) begin
            phase_r <= MSM_READ;
          end
        end
        MSM_WRITE: begin
          // sample while low, so the value kept is the settled bus
          if (m_strobe_wr) begin
            acc_data_r <= pin_r.data;
          end else begin
            phase_r <= MSM_IDLE;
          end
        end
        MSM_READ: begin
          if (!m_strobe_rd) begin
            phase_r <= MSM_IDLE;
          end
        end
        default: begin
          phase_r <= MSM_IDLE;
        end
      endcase
    end
  end

  assign status_now = status_byte(in_full_r, out_full_r, ev_r[`MSM_EV_IN0_WR], attn_r);

  // read data is latched as the read starts and held to its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_r <= `MSM_RST_BYTE;
    end else if (ce && phase_r == MSM_IDLE && m_strobe_rd) begin
      if (pin_r.addr == `MSM_SEL_STATUS) begin
        port_data_r <= status_now;
      end else begin
        port_data_r <= out_reg_r[pin_r.addr];
      end
    end
  end

  assign port_data_out = port_data_r;
  assign port_data_oe_n = !(phase_r == MSM_READ);

  // apb slave; zero wait states, pready follows ce so a frozen block stalls
  assign apb_setup = psel && !penable;
  assign apb_acc = psel && penable && ce;
  assign hit_in = bank_hit(paddr, `MSM_IN_BASE);
  assign hit_out = bank_hit(paddr, `MSM_OUT_BASE);
  assign hit_status = paddr == `MSM_STATUS_OFF;
  assign hit_ists = paddr == `MSM_IRQ_STS_OFF;
  assign hit_mask = paddr == `MSM_IRQ_MASK_OFF;
  assign mapped = |hit_in || |hit_out || hit_status || hit_ists || hit_mask;
  assign apb_wr = apb_acc && pwrite && mapped;
  assign apb_rd = apb_acc && !pwrite && mapped;
  assign pready = ce;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `MSM_RST_WORD;
    end else if (ce && apb_setup) begin
      prdata_r <= `MSM_RST_WORD;
      for (int i = 0; i < NREG; i++) begin
        if (hit_in[i]) begin
          prdata_r[7:0] <= in_reg_r[i];
        end
        if (hit_out[i]) begin
          prdata_r[7:0] <= out_reg_r[i];
        end
      end
      if (hit_status) begin
        prdata_r[7:0] <= status_now;
      end
      if (hit_ists) begin
        prdata_r[`MSM_EV_W-1:0] <= ev_r;
      end
      if (hit_mask) begin
        prdata_r[`MSM_EV_W-1:0] <= mask_r;
      end
    end
  end

  assign prdata = prdata_r;

  // inbound storage: only the master writes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        in_reg_r[i] <= `MSM_RST_BYTE;
      end
    end else if (ce && m_wr_done && acc_sel_r != `MSM_SEL_STATUS) begin
      in_reg_r[acc_sel_r] <= acc_data_r;
    end
  end

  // outbound storage: only the local cpu writes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        out_reg_r[i] <= `MSM_RST_BYTE;
      end
    end else if (ce && apb_wr && pstrb[0]) begin
      for (int i = 0; i < NREG; i++) begin
        if (hit_out[i]) begin
          out_reg_r[i] <= pwdata[7:0];
        end
      end
    end
  end

  // full flags; a store in the same cycle as a read wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_full_r <= `MSM_RST_FLAGS;
      out_full_r <= `MSM_RST_FLAGS;
    end else if (ce) begin
      for (int i = 0; i < NREG; i++) begin
        if (m_wr_done && acc_sel_r == 2'(i)) begin
          in_full_r[i] <= 1'b1;
        end else if (apb_rd && hit_in[i]) begin
          in_full_r[i] <= 1'b0;
        end
        if (apb_wr && pstrb[0] && hit_out[i]) begin
          out_full_r[i] <= 1'b1;
        end else if (m_rd_done && acc_sel_r == 2'(i)) begin
          out_full_r[i] <= 1'b0;
        end
      end
    end
  end

  // attention stays low until the master reads outbound zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attn_r <= 1'b0;
    end else if (ce) begin
      if (apb_wr && pstrb[0] && hit_out[0]) begin
        attn_r <= 1'b1;
      end else if (m_rd_done && acc_sel_r == `MSM_SEL_ZERO) begin
        attn_r <= 1'b0;
      end
    end
  end

  assign master_attention_out_n = !attn_r;

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_r <= `MSM_RST_EV;
    end else if (ce) begin
      if (apb_wr && hit_ists && pstrb[0]) begin
        ev_r <= ev_r & ~pwdata[`MSM_EV_W-1:0];
      end
      if (m_wr_done && acc_sel_r == `MSM_SEL_ZERO) begin
        ev_r[`MSM_EV_IN0_WR] <= 1'b1;
      end
      if (m_rd_done && acc_sel_r == `MSM_SEL_ZERO) begin
        ev_r[`MSM_EV_OUT0_RD] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `MSM_RST_EV;
    end else if (ce && apb_wr && hit_mask && pstrb[0]) begin
      mask_r <= pwdata[`MSM_EV_W-1:0];
    end
  end

  assign irq = |(ev_r & mask_r);

endmodule // msm_port

`default_nettype wire

// file: sim/msm_master_bfm.sv
// Purpose: outside master on the mailbox pins
// Assumes: strobe low 5 pclk, gap 5 pclk
// Notes: a released bus shows the inverse byte
`timescale 1ns/1ps
`default_nettype none
module msm_master_bfm (
  input wire logic pclk,
  output logic sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic a0,
  output logic a1,
  output logic [7:0] dq,
  input wire logic [7:0] q
);
  initial begin
    {sel_n, rd_n, wr_n, a1, a0} = 5'h1c;
    dq = 8'h00;
  end
  // select outlasts the strobe by a cycle so the strobe end is qualified
  task automatic xfer(input logic w, input logic [1:0] a, input logic [7:0] d,
    output logic [7:0] r);
    @(posedge pclk);
    {a1, a0} <= a;
    dq <= w ? d : ~dq;
    sel_n <= 0;
    if (w) wr_n <= 0;
    else rd_n <= 0;
    repeat (5) @(posedge pclk);
    r = q;
    {rd_n, wr_n} <= 2'h3;
    @(posedge pclk);
    sel_n <= 1;
    dq <= ~dq;
    repeat (4) @(posedge pclk);
  endtask
endmodule // msm_master_bfm
`default_nettype wire

// file: sim/msm_port_props.sv
// Purpose: port checks of the mailbox port
// Assumes: apb answers without wait states
// Notes: bound onto msm_port
`timescale 1ns/1ps
`default_nettype none
module msm_port_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic port_select_n,
  input wire logic port_read_strobe_n,
  input wire logic port_write_strobe_n,
  input wire logic reg_select_bit0,
  input wire logic reg_select_bit1,
  input wire logic port_data_oe_n,
  input wire logic master_attention_out_n,
  input wire logic [7:0] port_data_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(a);
    psel && penable && pwrite && ce && pstrb[0] && paddr == a;
  endsequence
  sequence s_rd0_end;
    $rose(port_read_strobe_n) && !port_select_n && !reg_select_bit0 && !reg_select_bit1;
  endsequence
  chk_attn_set: assert property (s_wr(12'h020) |=> !master_attention_out_n)
    else $error("attention not raised");
  chk_attn_quiet: assert property (psel && penable && pwrite && master_attention_out_n
    && (paddr == 12'h024 || paddr == 12'h028) |=> master_attention_out_n)
    else $error("attention from later register");
  chk_attn_clear: assert property (s_rd0_end |-> ##[2:5] master_attention_out_n)
    else $error("attention not released");
  chk_oe_read: assert property ($fell(port_read_strobe_n) && !port_select_n
    && port_write_strobe_n |-> ##3 !port_data_oe_n)
    else $error("read data not driven");
  chk_oe_idle: assert property (port_read_strobe_n [*5] |-> port_data_oe_n)
    else $error("bus driven without read");
  chk_data_hold: assert property (!port_data_oe_n && !$past(port_data_oe_n)
    |-> $stable(port_data_out))
    else $error("read data moved");
  chk_mask_off: assert property (s_wr(12'h034) ##0 (pwdata[1:0] == 2'h0) |-> ##2 !irq)
    else $error("masked event interrupts");
  chk_err_map: assert property (psel && penable && paddr == 12'h01c |-> pslverr)
    else $error("map hole answered");
endmodule // msm_port_props
bind msm_port msm_port_props u_chk (.*);
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: self-checking bench for the mailbox port
// Assumes: ce and pstrb held active outside t_misc
// Notes: expectations follow the bytes the bench sends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, irq, port_data_oe_n, master_attention_out_n;
  logic port_select_n, port_read_strobe_n, port_write_strobe_n, reg_select_bit0, reg_select_bit1;
  logic [7:0] port_data_in, port_data_out, v;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  msm_port uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .port_select_n(port_select_n),
    .port_read_strobe_n(port_read_strobe_n), .port_write_strobe_n(port_write_strobe_n),
    .reg_select_bit0(reg_select_bit0), .reg_select_bit1(reg_select_bit1),
    .port_data_in(port_data_in), .port_data_out(port_data_out),
    .port_data_oe_n(port_data_oe_n), .master_attention_out_n(master_attention_out_n)
  );
  msm_master_bfm u_mst (.pclk, .sel_n(port_select_n), .rd_n(port_read_strobe_n),
    .wr_n(port_write_strobe_n), .a0(reg_select_bit0), .a1(reg_select_bit1),
    .dq(port_data_in), .q(port_data_out));
  task automatic wrap_up;
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  // waits on pready rather than assuming zero wait states
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic t_in;
    apb(0, 12'h000, 0);
    chk("st", 0, rd);
    apb(1, 12'h034, 32'h1);
    u_mst.xfer(1, 2'h1, 8'h11, v);
    u_mst.xfer(1, 2'h2, 8'h22, v);
    chk("irq", 0, irq);
    u_mst.xfer(1, 2'h0, 8'h33, v);
    chk("irq", 1, irq);
    apb(0, 12'h000, 0);
    chk("st", 32'h0f, rd);
    for (int i = 0; i < 3; i++) begin
      apb(0, 12'h010 + 12'(4 * i), 0);
      chk("in", (32'h221133 >> (8 * i)) & 32'hff, rd);
    end
    apb(0, 12'h000, 0);
    chk("st", 32'h08, rd);
    u_mst.xfer(1, 2'h1, 8'h11, v);
    apb(0, 12'h000, 0);
    chk("st", 32'h0a, rd);
    apb(1, 12'h034, 0);
    @(posedge pclk);
    chk("irq", 0, irq);
    apb(1, 12'h030, 32'h3);
    apb(0, 12'h030, 0);
    chk("ev", 0, rd);
  endtask
  task automatic t_out;
    apb(1, 12'h024, 32'ha1);
    apb(1, 12'h028, 32'ha2);
    chk("attn", 1, master_attention_out_n);
    apb(1, 12'h020, 32'ha0);
    chk("attn", 0, master_attention_out_n);
    u_mst.xfer(0, 2'h3, 8'h00, v);
    chk("mst st", 8'hf2, v);
    u_mst.xfer(0, 2'h1, 8'h00, v);
    chk("out", 8'ha1, v);
    u_mst.xfer(0, 2'h0, 8'h00, v);
    chk("out", 8'ha0, v);
    chk("attn", 1, master_attention_out_n);
    apb(0, 12'h000, 0);
    chk("st", 32'h42, rd);
  endtask
  // second event source, refused writes and a frozen block
  task automatic t_misc;
    apb(0, 12'h030, 0);
    chk("ev", 32'h2, rd);
    apb(1, 12'h034, 32'h2);
    chk("irq", 1, irq);
    apb(1, 12'h030, 32'h2);
    chk("irq", 0, irq);
    apb(1, 12'h034, 0);
    u_mst.xfer(1, 2'h3, 8'h55, v);
    apb(0, 12'h000, 0);
    chk("st", 32'h42, rd);
    chk("oe", 1, port_data_oe_n);
    pstrb <= 4'he;
    apb(1, 12'h020, 32'hbb);
    pstrb <= 4'hf;
    chk("attn", 1, master_attention_out_n);
    apb(0, 12'h020, 0);
    chk("out", 32'ha0, rd);
    ce <= 0;
    @(posedge pclk);
    chk("rdy", 0, pready);
    ce <= 1;
  endtask
  // reset in mid-run drops attention, clears the status byte and empties outbound zero
  task automatic t_rst;
    apb(1, 12'h020, 32'ha5);
    chk("attn", 0, master_attention_out_n);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("attn", 1, master_attention_out_n);
    presetn <= 1;
    apb(0, 12'h000, 0);
    chk("st", 0, rd);
    apb(0, 12'h020, 0);
    chk("out", 0, rd);
  endtask
  task automatic t_hole;
    apb(0, 12'h01c, 0);
    chk("err", 1, se);
  endtask
  always @(posedge pclk) begin
    if (++cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_in();
    t_out();
    t_misc();
    t_rst();
    t_hole();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
